/* File: ppri_pin_protect.sv */
// Side-band pin logic: per-die error interrupts, shared reset, hardware write protect
// Functional notes
// - Die one pulls its interrupt low on read failure
// - Die two pulls its own interrupt independently
// - Reset high: normal mode, instructions accepted
// - Reset low: held in reset, outputs high impedance
// - One reset input resets both dies together
// - Protect pins size a write-rejecting array region
// - Protect size pins pull down when unconnected
// - Select pin places region at top or bottom
// - Select pin pulls down when unconnected
`timescale 1ns/1ps
`default_nettype none
module ppri_pin_protect
    import ppri_pkg::*;
#(
    parameter int NUM_DIES = DIE_CNT
)
(
    input  wire logic                              core_clk,
    input  wire logic                              rstn,
    input  wire ppri_die_evt_type [DIE_CNT-1:0]    die_evt,
    input  wire logic [DIE_CNT-1:0]                irq_clr,
    input  wire ppri_pin_type [PROT_W-1:0]         hw_protect_size_sel,
    input  wire ppri_pin_type                      hw_protect_top_bottom_sel,
    input  wire ppri_wr_req_type                   wr_req,
    output logic                                   instr_ready,
    output ppri_wr_res_type                        wr_res_q,
    output logic                                   die1_ecc_fail_irq_n,
    output logic                                   die1_ecc_fail_irq_oe,
    output logic                                   die2_ecc_fail_irq_n,
    output logic                                   die2_ecc_fail_irq_oe
);

    // Refuse a die count the pin map cannot serve
    if (NUM_DIES != DIE_CNT) begin : g_bad_dies
        $error("NUM_DIES must equal the two-die pin map");
    end

    logic [DIE_CNT-1:0]    flag_q;
    logic [DIE_CNT-1:0]    err_evt;
    logic [PROT_W-1:0]     prot_size;
    logic                  prot_top;
    logic                  oe_q;
    logic [4:0]            len_log;
    logic [ADDR_W-1:0]     low_ones;
    logic [ADDR_W-1:0]     hi_mask;
    logic                  prot_hit;

    // Per-die sticky error flags; one reset clears every die at once
    for (genvar d = 0; d < DIE_CNT; d++) begin : g_die
        assign err_evt[d] = die_evt[d].rd_active & die_evt[d].ecc_uncorr;
        ppri_irq_latch u_latch (
            .core_clk (core_clk),
            .rstn     (rstn),
            .err_evt  (err_evt[d]),
            .clr      (irq_clr[d]),
            .flag_q   (flag_q[d])
        );
    end

    // Undriven protect pins read as the pull-down level
    for (genvar b = 0; b < PROT_W; b++) begin : g_size_pin
        assign prot_size[b] = hw_protect_size_sel[b].drv ?
                              hw_protect_size_sel[b].lvl : PULL_LVL;
    end
    assign prot_top = hw_protect_top_bottom_sel.drv ?
                      hw_protect_top_bottom_sel.lvl : PULL_LVL;

    // Instructions are taken only while out of reset
    assign instr_ready = rstn;

    // Output drivers come on one edge after reset release, off at once in reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            oe_q <= OE_RST;
        end else begin
            oe_q <= 1'h1;
        end
    end

    // Interrupt pins: low on a caught failure, high otherwise, floating in reset
    assign die1_ecc_fail_irq_n  = ~flag_q[0];
    assign die2_ecc_fail_irq_n  = ~flag_q[1];
    assign die1_ecc_fail_irq_oe = oe_q & rstn;
    assign die2_ecc_fail_irq_oe = oe_q & rstn;

    // Region of 2^(ADDR_W-7+size) bytes; size zero protects nothing, seven all
    always_comb begin
        len_log  = 5'(ADDR_W - PROT_STEPS) + 5'(prot_size);
        low_ones = (ADDR_W'(1) << len_log) - ADDR_W'(1);
        hi_mask  = ~low_ones;
        prot_hit = 1'h0;
        if (prot_size != PROT_NONE) begin
            if (prot_top) begin
                prot_hit = (wr_req.addr & hi_mask) == hi_mask;
            end else begin
                prot_hit = (wr_req.addr & hi_mask) == '0;
            end
        end
    end

    // Verdict on each write request, one cycle later
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_res_q <= '0;
        end else begin
            wr_res_q.valid   <= wr_req.valid;
            wr_res_q.blocked <= wr_req.valid & prot_hit;
        end
    end

    default clocking cb @(posedge core_clk); endclocking

    // Failure on die one shows on its pin next cycle
    irq1_set_a : assert property (disable iff (!rstn)
        err_evt[0] |=> !die1_ecc_fail_irq_n)
        else $error("die one failure not reported");

    // Die one failure alone leaves die two pin quiet
    irq2_indep_a : assert property (disable iff (!rstn)
        err_evt[0] && !err_evt[1] && !flag_q[1] |=> die2_ecc_fail_irq_n)
        else $error("die two pin moved on die one failure");

    // Failure on die two shows on its pin next cycle
    irq2_set_a : assert property (disable iff (!rstn)
        err_evt[1] |=> !die2_ecc_fail_irq_n)
        else $error("die two failure not reported");

    // Out of reset, instructions are accepted
    ready_run_a : assert property (rstn |-> instr_ready)
        else $error("not ready out of reset");

    // Drivers are on again from the second edge after release
    oe_run_a : assert property (
        !rstn ##1 rstn ##1 rstn |-> die1_ecc_fail_irq_oe && die2_ecc_fail_irq_oe)
        else $error("driver still off after reset release");

    // In reset, both interrupt drivers float
    hiz_reset_a : assert property (
        !rstn |-> !die1_ecc_fail_irq_oe && !die2_ecc_fail_irq_oe)
        else $error("driver active in reset");

    // In reset, no instruction is accepted
    rst_quiet_a : assert property (
        !rstn |-> !instr_ready)
        else $error("ready while in reset");

    // Reset clears both dies together and leaves pins high in the first cycle after release
    both_reset_a : assert property (
        !rstn ##1 rstn && !err_evt[0] && !err_evt[1]
        |-> die1_ecc_fail_irq_n && die2_ecc_fail_irq_n && !wr_res_q.valid)
        else $error("a die left set after reset");

    // Writes inside the region are rejected
    prot_block_a : assert property (disable iff (!rstn)
        wr_req.valid && prot_hit |=> wr_res_q.valid && wr_res_q.blocked)
        else $error("protected write not blocked");

    // Size zero never blocks
    prot_none_a : assert property (disable iff (!rstn)
        wr_req.valid && prot_size == PROT_NONE |=> !wr_res_q.blocked)
        else $error("write blocked with no region");

    // A blocked verdict always belongs to a request
    blk_valid_a : assert property (disable iff (!rstn)
        wr_res_q.blocked |-> wr_res_q.valid)
        else $error("blocked verdict without request");

    // Undriven size pin zero reads low
    size_pull_a : assert property (disable iff (!rstn)
        !hw_protect_size_sel[0].drv |-> !prot_size[0])
        else $error("undriven size pin not low");

    // Top region catches the last address, bottom region the first
    top_bottom_a : assert property (disable iff (!rstn)
        wr_req.valid && prot_size != PROT_NONE
        && ((prot_top && &wr_req.addr) || (!prot_top && ~|wr_req.addr))
        |=> wr_res_q.blocked)
        else $error("region end not protected");

    // A top region short of the whole array never reaches the lower half
    prot_pass_top_a : assert property (disable iff (!rstn)
        wr_req.valid && prot_top && prot_size != PROT_W'(PROT_STEPS)
        && !wr_req.addr[ADDR_W-1]
        |=> !wr_res_q.blocked)
        else $error("write below top region blocked");

    // A bottom region short of the whole array never reaches the upper half
    prot_pass_bot_a : assert property (disable iff (!rstn)
        wr_req.valid && !prot_top && prot_size != PROT_W'(PROT_STEPS)
        && wr_req.addr[ADDR_W-1]
        |=> !wr_res_q.blocked)
        else $error("write above bottom region blocked");

    // Undriven select pin means bottom
    sel_pull_a : assert property (
        !hw_protect_top_bottom_sel.drv |-> !prot_top)
        else $error("undriven select pin not low");

    // Pin stays high while nothing set the flag
    idle_high_a : assert property (disable iff (!rstn)
        die1_ecc_fail_irq_n && !err_evt[0] |=> die1_ecc_fail_irq_n)
        else $error("interrupt fell with no failure");

    // Pin two stays high while nothing set its flag
    idle_high2_a : assert property (disable iff (!rstn)
        die2_ecc_fail_irq_n && !err_evt[1] |=> die2_ecc_fail_irq_n)
        else $error("interrupt two fell with no failure");

    // A clear with no new failure raises pin one again
    clr_rise1_a : assert property (disable iff (!rstn)
        irq_clr[0] && !err_evt[0] |=> die1_ecc_fail_irq_n)
        else $error("interrupt one not released by clear");

    // A clear with no new failure raises pin two again
    clr_rise2_a : assert property (disable iff (!rstn)
        irq_clr[1] && !err_evt[1] |=> die2_ecc_fail_irq_n)
        else $error("interrupt two not released by clear");

    // Main scenarios
    irq1_seen_c  : cover property (disable iff (!rstn) err_evt[0] ##[1:8] irq_clr[0]);
    irq_both_c   : cover property (disable iff (!rstn) err_evt[0] && err_evt[1]);
    top_block_c  : cover property (disable iff (!rstn) wr_req.valid && prot_hit && prot_top);
    reset_seen_c : cover property (!rstn ##1 rstn);

endmodule : ppri_pin_protect
`default_nettype wire

/* File: ppri_pkg.sv */
// Shared constants and carrier types for the side-band pin block
package ppri_pkg;

    // Die count and array address width in bits
    localparam int DIE_CNT    = 2;
    localparam int ADDR_W     = 24;

    // Hardware protect size field
    localparam int PROT_W     = 3;
    localparam int PROT_STEPS = 7;
    localparam logic [PROT_W-1:0] PROT_NONE = 3'h0;

    // Level read from an undriven pin that has a pull-down
    localparam logic PULL_LVL = 1'h0;

    // Reset values
    localparam logic IRQ_FLAG_RST = 1'h0;
    localparam logic OE_RST       = 1'h0;

    // A pin as seen from inside: level and whether the far side drives it
    typedef struct packed {
        logic lvl;
        logic drv;
    } ppri_pin_type;

    // Per-die read status from the die core
    typedef struct packed {
        logic rd_active;
        logic ecc_uncorr;
    } ppri_die_evt_type;

    // Array write request from the instruction decoder
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } ppri_wr_req_type;

    // Registered verdict on a write request
    typedef struct packed {
        logic valid;
        logic blocked;
    } ppri_wr_res_type;

endpackage : ppri_pkg

/* File: ppri_irq_latch.sv */
// Sticky uncorrectable-error flag for one die
`timescale 1ns/1ps
`default_nettype none
module ppri_irq_latch
    import ppri_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic err_evt,
    input  wire logic clr,
    output var  logic flag_q
);

    // Set wins over clear; reset empties the flag
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flag_q <= IRQ_FLAG_RST;
        end else if (err_evt) begin
            flag_q <= 1'h1;
        end else if (clr) begin
            flag_q <= 1'h0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Flag set by an event and held while no clear
    set_wins_a : assert property (err_evt |=> flag_q)
        else $error("error event did not set flag");
    hold_flag_a : assert property (flag_q && !clr |=> flag_q)
        else $error("flag dropped without clear");

endmodule : ppri_irq_latch
`default_nettype wire

/* File: ppri_host_model.sv */
// Host-side driver model for the hardware protect pins
`timescale 1ns/1ps
`default_nettype none
module ppri_host_model
    import ppri_pkg::*;
(
    input  wire logic [PROT_W-1:0]        size_lvl,
    input  wire logic [PROT_W-1:0]        size_drv,
    input  wire logic                     top_lvl,
    input  wire logic                     top_drv,
    output var  ppri_pin_type [PROT_W-1:0] size_pin,
    output var  ppri_pin_type             top_pin
);
    // Released pins show a stale high level, so only the drive bit may be trusted
    always_comb begin
        for (int i = 0; i < PROT_W; i++) begin
            size_pin[i].drv = size_drv[i];
            size_pin[i].lvl = size_drv[i] ? size_lvl[i] : 1'h1;
        end
        top_pin.drv = top_drv;
        top_pin.lvl = top_drv ? top_lvl : 1'h1;
    end
endmodule : ppri_host_model
`default_nettype wire

/* File: tb_pin_protect_reset_interrupt.sv */
// Self-checking bench for the side-band pin block
`timescale 1ns/1ps
`default_nettype none
module tb_pin_protect_reset_interrupt;
    import ppri_pkg::*;
    logic                            core_clk = 1'h0;
    logic                            rstn     = 1'h0;
    ppri_die_evt_type [DIE_CNT-1:0]  die_evt  = '0;
    logic [DIE_CNT-1:0]              irq_clr  = '0;
    logic [PROT_W-1:0]               size_lvl = '0;
    logic [PROT_W-1:0]               size_drv = '0;
    logic                            top_lvl  = 1'h0;
    logic                            top_drv  = 1'h0;
    ppri_wr_req_type                 wr_req   = '0;
    ppri_pin_type [PROT_W-1:0]       size_pin;
    ppri_pin_type                    top_pin;
    ppri_wr_res_type                 wr_res_q;
    logic                            instr_ready;
    logic [1:0]                      irq_n;
    logic [1:0]                      irq_oe;
    int                              errors   = 0;
    int                              n_tests  = 0;

    // Clock at 100 MHz
    always #5 core_clk = ~core_clk;

    ppri_host_model HOST (.size_lvl(size_lvl), .size_drv(size_drv), .top_lvl(top_lvl),
        .top_drv(top_drv), .size_pin(size_pin), .top_pin(top_pin));

    ppri_pin_protect #(.NUM_DIES(2)) DUT (.core_clk(core_clk), .rstn(rstn),
        .die_evt(die_evt), .irq_clr(irq_clr), .hw_protect_size_sel(size_pin),
        .hw_protect_top_bottom_sel(top_pin), .wr_req(wr_req), .instr_ready(instr_ready),
        .wr_res_q(wr_res_q), .die1_ecc_fail_irq_n(irq_n[0]), .die1_ecc_fail_irq_oe(irq_oe[0]),
        .die2_ecc_fail_irq_n(irq_n[1]), .die2_ecc_fail_irq_oe(irq_oe[1]));

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Move n cycles on, inputs change 1 ns after the last edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // One write request, verdict taken one cycle later; valid is left high
    task automatic wr_try(input int addr, input logic exp);
        wr_req = '{1'h1, addr[ADDR_W-1:0]};
        tick(1);
        chk(wr_res_q.valid, 1'h1);
        chk(wr_res_q.blocked, exp);
    endtask : wr_try

    // Error on die d: no effect without a read, then flagged and cleared
    task automatic err_die(input int d);
        die_evt[d] = '{1'h0, 1'h1};
        tick(2);
        chk(irq_n, 2'h3);
        die_evt[d] = '{1'h1, 1'h1};
        tick(1);
        die_evt[d] = '0;
        chk(irq_n, d ? 2'h1 : 2'h2);
        tick(3);
        chk(irq_n, d ? 2'h1 : 2'h2);
        irq_clr[d] = 1'h1;
        tick(1);
        chk(irq_n, 2'h3);
        // Failure and clear in one cycle: the failure wins
        die_evt[d] = '{1'h1, 1'h1};
        tick(1);
        die_evt[d] = '0;
        chk(irq_n, d ? 2'h1 : 2'h2);
        tick(1);
        irq_clr[d] = 1'h0;
        chk(irq_n, 2'h3);
    endtask : err_die

    // Region sizes at both ends, boundary addresses inside and outside
    task automatic prot_sweep();
        int sz;
        for (int s = 0; s < 8; s++) begin
            sz = 1 << (17 + s);
            size_lvl = s[2:0];
            size_drv = 3'h7;
            top_drv = 1'h1;
            top_lvl = 1'h1;
            wr_try((1 << 24) - sz, s > 0);
            if (s < 7) wr_try((1 << 24) - sz - 1, 1'h0);
            top_lvl = 1'h0;
            wr_try(sz - 1, s > 0);
            if (s < 7) wr_try(sz, 1'h0);
        end
        size_drv = 3'h0;
        wr_try(24'hFFFFFF, 1'h0);
        size_drv = 3'h7;
        size_lvl = 3'h1;
        top_drv = 1'h0;
        wr_try(0, 1'h1);
        wr_try(24'hFFFFFF, 1'h0);
        wr_req.valid = 1'h0;
    endtask : prot_sweep

    // Reset in mid-run with both flags set clears both dies and floats pins
    task automatic mid_reset();
        die_evt = '{'{1'h1, 1'h1}, '{1'h1, 1'h1}};
        tick(1);
        chk(irq_n, 2'h0);
        die_evt = '0;
        rstn = 1'h0;
        #1;
        chk({instr_ready, irq_oe}, 3'h0);
        tick(1);
        chk(irq_n, 2'h3);
        rstn = 1'h1;
        tick(1);
        chk({instr_ready, irq_oe}, 3'h7);
    endtask : mid_reset

    task automatic complete_run();
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        tick(8);
        chk({instr_ready, irq_oe}, 3'h0);
        rstn = 1'h1;
        #1;
        chk(instr_ready, 1'h1);
        tick(1);
        chk({irq_oe, irq_n}, 4'hF);
        err_die(0);
        err_die(1);
        prot_sweep();
        mid_reset();
        complete_run();
    end

    // Hang guard
    initial begin
        #500000;
        errors++;
        complete_run();
    end
endmodule : tb_pin_protect_reset_interrupt
`default_nettype wire
